// ### src/svsmc_defs.vh
`ifndef SVSMC_DEFS_VH
`define SVSMC_DEFS_VH

// ----------------------------------------
// Timing
// ----------------------------------------
`define SVSMC_CLK_MHZ 10
`define SVSMC_FRST_DELAY_US 3000
// Fault reset wait in clocks: 3 ms at 10 MHz
`define SVSMC_FRST_CYCLES 16'h7530

// ----------------------------------------
// Object indexes
// ----------------------------------------
`define SVSMC_IDX_QSTOP_OPT 16'h605A
`define SVSMC_IDX_DIS_OPT 16'h605C
`define SVSMC_IDX_FLT_OPT 16'h605E
`define SVSMC_IDX_ESTOP_LOGIC 16'h2000
`define SVSMC_IDX_IN_FUNC_BASE 16'h2001
`define SVSMC_IDX_IN_FUNC_LAST 16'h2005
`define SVSMC_IDX_STATUS 16'h2010

// ----------------------------------------
// Reset values
// ----------------------------------------
`define SVSMC_QSTOP_OPT_RST 16'h0002
`define SVSMC_DIS_OPT_RST 16'h0002
`define SVSMC_FLT_OPT_RST 16'h0001
`define SVSMC_ESTOP_LOGIC_RST 16'h0006
`define SVSMC_IN_FUNC_RST 16'h0000

// ----------------------------------------
// Codes
// ----------------------------------------
`define SVSMC_FN_FWD_NO 16'h0002
`define SVSMC_FN_REV_NO 16'h0003
`define SVSMC_FN_FWD_NC 16'h0066
`define SVSMC_FN_REV_NC 16'h0067
`define SVSMC_ESTOP_NO 16'h0006
`define SVSMC_ESTOP_NC 16'h006A
`define SVSMC_QSTOP_BIT 2
`define SVSMC_NUM_INPUTS 5

// Stop profile driven to the motion core
`define SVSMC_SM_COAST 2'h0
`define SVSMC_SM_DECEL 2'h1
`define SVSMC_SM_FAST 2'h2
`define SVSMC_SM_ZERO 2'h3

`endif

// ### src/svsmc_input_map.v
`timescale 1ns/10ps
`include "svsmc_defs.vh"

module svsmc_input_map (
    input wire [`SVSMC_NUM_INPUTS-1:0] gen_in,
    input wire [16*`SVSMC_NUM_INPUTS-1:0] in_func,
    output reg fwd_limit,
    output reg rev_limit
);
    integer i;
    reg [15:0] fn;

    always @* begin
        fwd_limit = 1'b0;
        rev_limit = 1'b0;
        fn = 16'h0000;
        for (i = 0; i < `SVSMC_NUM_INPUTS; i = i + 1) begin
            fn = in_func[16*i +: 16];
            // Normally open valid high, normally closed valid low
            if ((fn == `SVSMC_FN_FWD_NO && gen_in[i]) ||
                (fn == `SVSMC_FN_FWD_NC && !gen_in[i])) begin
                fwd_limit = 1'b1;
            end
            if ((fn == `SVSMC_FN_REV_NO && gen_in[i]) ||
                (fn == `SVSMC_FN_REV_NC && !gen_in[i])) begin
                rev_limit = 1'b1;
            end
        end
    end
endmodule

// ### src/svsmc_delay.v
`timescale 1ns/10ps
`include "svsmc_defs.vh"

module svsmc_delay #(
    parameter [15:0] COUNT = `SVSMC_FRST_CYCLES
) (
    input wire ref_clk,
    input wire resetn,
    input wire clk_en,
    input wire run,
    output wire done
);
    reg [15:0] cnt_ff;
    wire [15:0] nxt_cnt;

    // Counter restarts whenever run drops
    assign nxt_cnt = !run ? 16'h0000 : (done ? cnt_ff : cnt_ff + 16'h0001);
    assign done = run && (cnt_ff >= COUNT);

    always @(posedge ref_clk or negedge resetn) begin
        if (!resetn) begin
            cnt_ff <= 16'h0000;
        end else if (clk_en) begin
            cnt_ff <= nxt_cnt;
        end
    end
endmodule

// ### src/svsmc_stop_ctrl.v
`timescale 1ns/10ps
`include "svsmc_defs.vh"

// Summary of operation
// - Disable code 0: output off, coast
// - Disable code 1: ramp down, then off
// - Disable code used leaving operation enabled
// - Disable stop selection only in bus mode
// - Fault code 0 coast, 1 ramp, 2 fast
// - Fault code 3: max-current zero-speed stop
// - Fault stop runs before fault state
// - Overtravel: zero-speed stop, then position lock
// - Reverse command still accepted in overtravel
// - Five inputs assignable as limit functions
// - Codes 2/3 open, 102/103 closed
// - Emergency input triggers quick stop
// - Emergency logic 6 open, 106 closed
// - Brake stop: de-energise, brake holds
// - Zero-speed stop applies reverse torque
// - Drive-off end: unpowered, brake locks
// - Position-hold end keeps shaft locked
// - Control word bit 2 clear: quick stop

module svsmc_stop_ctrl #(
    parameter [15:0] FRST_CYCLES = `SVSMC_FRST_CYCLES
) (
    input wire ref_clk,
    input wire resetn,
    input wire clk_en,
    input wire [15:0] od_index,
    input wire od_wr,
    input wire [15:0] od_wdata,
    output reg [15:0] od_rdata_ff,
    input wire bus_mode,
    input wire [15:0] ctrl_word,
    input wire enable_req,
    input wire alarm_in,
    input wire fault_reset,
    input wire [4:0] gen_in,
    input wire estop_in,
    input wire cmd_fwd,
    input wire cmd_rev,
    input wire motor_stopped,
    input wire brake_fitted,
    output reg drive_on_ff,
    output reg [1:0] stop_mode_ff,
    output reg pos_lock_ff,
    output reg brake_hold_ff,
    output reg fault_out_ff,
    output reg fwd_block_ff,
    output reg rev_block_ff,
    output reg overtravel_ff,
    output reg [2:0] state_ff
);
    // ----------------------------------------
    // States
    // ----------------------------------------
    localparam [2:0] ST_SWON = 3'h0;
    localparam [2:0] ST_OPEN = 3'h1;
    localparam [2:0] ST_DSTOP = 3'h2;
    localparam [2:0] ST_QSTOP = 3'h3;
    localparam [2:0] ST_FSTOP = 3'h4;
    localparam [2:0] ST_FAULT = 3'h5;
    localparam [2:0] ST_FRST = 3'h6;

    // ----------------------------------------
    // Object registers
    // ----------------------------------------
    reg [15:0] qstop_opt_ff;
    reg [15:0] dis_opt_ff;
    reg [15:0] flt_opt_ff;
    reg [15:0] estop_logic_ff;
    reg [16*`SVSMC_NUM_INPUTS-1:0] in_func_ff;
    reg [15:0] nxt_rdata;
    integer k;

    always @(posedge ref_clk or negedge resetn) begin
        if (!resetn) begin
            qstop_opt_ff <= `SVSMC_QSTOP_OPT_RST;
            dis_opt_ff <= `SVSMC_DIS_OPT_RST;
            flt_opt_ff <= `SVSMC_FLT_OPT_RST;
            estop_logic_ff <= `SVSMC_ESTOP_LOGIC_RST;
            in_func_ff <= {`SVSMC_NUM_INPUTS{`SVSMC_IN_FUNC_RST}};
        end else if (clk_en && od_wr) begin
            if (od_index == `SVSMC_IDX_QSTOP_OPT) begin
                qstop_opt_ff <= od_wdata;
            end else if (od_index == `SVSMC_IDX_DIS_OPT) begin
                dis_opt_ff <= od_wdata;
            end else if (od_index == `SVSMC_IDX_FLT_OPT) begin
                flt_opt_ff <= od_wdata;
            end else if (od_index == `SVSMC_IDX_ESTOP_LOGIC) begin
                estop_logic_ff <= od_wdata;
            end else if (od_index >= `SVSMC_IDX_IN_FUNC_BASE &&
                         od_index <= `SVSMC_IDX_IN_FUNC_LAST) begin
                for (k = 0; k < `SVSMC_NUM_INPUTS; k = k + 1) begin
                    if (od_index == `SVSMC_IDX_IN_FUNC_BASE + k[15:0]) begin
                        in_func_ff[16*k +: 16] <= od_wdata;
                    end
                end
            end
        end
    end

    always @* begin
        nxt_rdata = 16'h0000;
        if (od_index == `SVSMC_IDX_QSTOP_OPT) begin
            nxt_rdata = qstop_opt_ff;
        end else if (od_index == `SVSMC_IDX_DIS_OPT) begin
            nxt_rdata = dis_opt_ff;
        end else if (od_index == `SVSMC_IDX_FLT_OPT) begin
            nxt_rdata = flt_opt_ff;
        end else if (od_index == `SVSMC_IDX_ESTOP_LOGIC) begin
            nxt_rdata = estop_logic_ff;
        end else if (od_index >= `SVSMC_IDX_IN_FUNC_BASE &&
                     od_index <= `SVSMC_IDX_IN_FUNC_LAST) begin
            for (k = 0; k < `SVSMC_NUM_INPUTS; k = k + 1) begin
                if (od_index == `SVSMC_IDX_IN_FUNC_BASE + k[15:0]) begin
                    nxt_rdata = in_func_ff[16*k +: 16];
                end
            end
        end else if (od_index == `SVSMC_IDX_STATUS) begin
            nxt_rdata = {5'h00, state_ff, drive_on_ff, stop_mode_ff, pos_lock_ff,
                         fault_out_ff, overtravel_ff, fwd_block_ff, rev_block_ff};
        end
    end

    always @(posedge ref_clk or negedge resetn) begin
        if (!resetn) begin
            od_rdata_ff <= 16'h0000;
        end else if (clk_en) begin
            od_rdata_ff <= nxt_rdata;
        end
    end

    // ----------------------------------------
    // Input decode
    // ----------------------------------------
    wire fwd_limit;
    wire rev_limit;
    wire estop_valid;
    wire qstop_req;
    wire frst_done;

    svsmc_input_map u_map (
        .gen_in(gen_in),
        .in_func(in_func_ff),
        .fwd_limit(fwd_limit),
        .rev_limit(rev_limit)
    );

    // Unknown logic codes fall back to open contact handling
    assign estop_valid = (estop_logic_ff == `SVSMC_ESTOP_NC) ? !estop_in
                                                             : estop_in;
    assign qstop_req = estop_valid || !ctrl_word[`SVSMC_QSTOP_BIT];

    svsmc_delay #(
        .COUNT(FRST_CYCLES)
    ) u_frst (
        .ref_clk(ref_clk),
        .resetn(resetn),
        .clk_en(clk_en),
        .run(state_ff == ST_FRST),
        .done(frst_done)
    );

    // ----------------------------------------
    // Stop selection
    // ----------------------------------------
    function [1:0] map_opt;
        input [15:0] opt;
        begin
            if (opt == 16'h0001) begin
                map_opt = `SVSMC_SM_DECEL;
            end else if (opt == 16'h0002) begin
                map_opt = `SVSMC_SM_FAST;
            end else if (opt == 16'h0003) begin
                map_opt = `SVSMC_SM_ZERO;
            end else begin
                map_opt = `SVSMC_SM_COAST;
            end
        end
    endfunction

    reg [2:0] nxt_state;
    reg [1:0] nxt_mode;
    reg nxt_drive;
    reg nxt_lock;
    reg nxt_fault;
    reg nxt_ot;
    wire ot_hit;

    // Only the direction pushing into a valid limit is stopped
    assign ot_hit = (fwd_limit && cmd_fwd) || (rev_limit && cmd_rev);

    always @* begin
        nxt_state = state_ff;
        nxt_mode = stop_mode_ff;
        nxt_drive = drive_on_ff;
        nxt_lock = pos_lock_ff;
        nxt_fault = fault_out_ff;
        nxt_ot = overtravel_ff;
        case (state_ff)
            ST_SWON: begin
                nxt_drive = 1'b0;
                nxt_lock = 1'b0;
                if (alarm_in) begin
                    nxt_state = ST_FAULT;
                    nxt_fault = 1'b1;
                end else if (enable_req && !qstop_req) begin
                    nxt_state = ST_OPEN;
                    nxt_drive = 1'b1;
                    nxt_mode = `SVSMC_SM_COAST;
                end
            end
            ST_OPEN: begin
                if (alarm_in) begin
                    nxt_state = ST_FSTOP;
                    nxt_mode = map_opt(flt_opt_ff);
                    nxt_ot = 1'b0;
                    nxt_lock = 1'b0;
                end else if (qstop_req) begin
                    nxt_state = ST_QSTOP;
                    nxt_mode = map_opt(qstop_opt_ff);
                    nxt_ot = 1'b0;
                    nxt_lock = 1'b0;
                end else if (!enable_req) begin
                    nxt_state = ST_DSTOP;
                    nxt_ot = 1'b0;
                    nxt_lock = 1'b0;
                    // Outside bus mode the selection is ignored: plain coast
                    nxt_mode = bus_mode ? map_opt(dis_opt_ff)
                                        : `SVSMC_SM_COAST;
                end else if (ot_hit) begin
                    nxt_ot = 1'b1;
                    nxt_mode = `SVSMC_SM_ZERO;
                    if (motor_stopped) begin
                        nxt_lock = 1'b1;
                    end
                end else begin
                    nxt_ot = 1'b0;
                    nxt_lock = 1'b0;
                    nxt_mode = `SVSMC_SM_COAST;
                end
            end
            ST_DSTOP, ST_QSTOP, ST_FSTOP: begin
                if (state_ff != ST_FSTOP && alarm_in) begin
                    nxt_state = ST_FSTOP;
                    nxt_mode = map_opt(flt_opt_ff);
                end else if (motor_stopped || stop_mode_ff == `SVSMC_SM_COAST) begin
                    // Coast cuts output at once, a ramp only once at rest
                    nxt_drive = 1'b0;
                    nxt_mode = `SVSMC_SM_COAST;
                    if (state_ff == ST_FSTOP) begin
                        nxt_state = ST_FAULT;
                        nxt_fault = 1'b1;
                    end else if (motor_stopped) begin
                        nxt_state = ST_SWON;
                    end
                end
            end
            ST_FAULT: begin
                nxt_drive = 1'b0;
                nxt_fault = 1'b1;
                if (fault_reset && !alarm_in) begin
                    nxt_state = ST_FRST;
                end
            end
            ST_FRST: begin
                if (alarm_in) begin
                    nxt_state = ST_FAULT;
                end else if (frst_done) begin
                    nxt_state = ST_SWON;
                    nxt_fault = 1'b0;
                end
            end
            default: begin
                nxt_state = ST_SWON;
            end
        endcase
    end

    always @(posedge ref_clk or negedge resetn) begin
        if (!resetn) begin
            state_ff <= ST_SWON;
            stop_mode_ff <= `SVSMC_SM_COAST;
            drive_on_ff <= 1'b0;
            pos_lock_ff <= 1'b0;
            brake_hold_ff <= 1'b0;
            fault_out_ff <= 1'b0;
            overtravel_ff <= 1'b0;
            fwd_block_ff <= 1'b0;
            rev_block_ff <= 1'b0;
        end else if (clk_en) begin
            state_ff <= nxt_state;
            stop_mode_ff <= nxt_mode;
            drive_on_ff <= nxt_drive;
            pos_lock_ff <= nxt_lock;
            // Brake holds whenever a brake is fitted and the motor is unpowered
            brake_hold_ff <= brake_fitted && !nxt_drive;
            fault_out_ff <= nxt_fault;
            overtravel_ff <= nxt_ot;
            fwd_block_ff <= fwd_limit;
            rev_block_ff <= rev_limit;
        end
    end
endmodule

// ### test/svsmc_monitor.sv
`timescale 1ns/10ps

module svsmc_monitor #(
    parameter [15:0] FRST_CYCLES = 16'h7530
) (
    input wire ref_clk,
    input wire resetn,
    input wire clk_en,
    input wire [15:0] ctrl_word,
    input wire alarm_in,
    input wire motor_stopped,
    input wire brake_fitted,
    input wire drive_on_ff,
    input wire [1:0] stop_mode_ff,
    input wire brake_hold_ff,
    input wire fault_out_ff,
    input wire overtravel_ff,
    input wire [2:0] state_ff
);
    reg [15:0] wait_cnt_ff;
    wire [15:0] nxt_wait_cnt;

    // Cycles spent in fault reset wait
    assign nxt_wait_cnt = (state_ff == 3'h6) ? wait_cnt_ff + 16'h0001 : 16'h0000;
    always @(posedge ref_clk or negedge resetn) begin
        if (!resetn) begin
            wait_cnt_ff <= 16'h0000;
        end else if (clk_en) begin
            wait_cnt_ff <= nxt_wait_cnt;
        end
    end

    default clocking @(posedge ref_clk); endclocking
    default disable iff (!resetn);

    a_fault_out_on: assert property (state_ff == 3'h5 |-> fault_out_ff)
        else $error("fault output low in fault state");
    a_alarm_fstop: assert property (clk_en && state_ff == 3'h1 && alarm_in
        |=> state_ff == 3'h4) else $error("alarm did not start fault stop");
    a_qstop_entry: assert property (clk_en && state_ff == 3'h1 && !alarm_in
        && !ctrl_word[2] |=> state_ff == 3'h3) else $error("quick stop not entered");
    a_ot_zero: assert property (state_ff == 3'h1 && overtravel_ff
        |-> stop_mode_ff == 2'h3) else $error("overtravel stop not zero speed");
    a_frst_out: assert property (state_ff == 3'h6 |-> fault_out_ff)
        else $error("fault output dropped early");
    a_frst_delay: assert property ($past(state_ff) == 3'h6 && state_ff == 3'h0
        |-> wait_cnt_ff >= FRST_CYCLES) else $error("fault reset delay too short");
    a_dis_done: assert property (clk_en && state_ff == 3'h2
        && motor_stopped && !alarm_in |=> state_ff == 3'h0 && !drive_on_ff)
        else $error("disable stop did not end unpowered");
    a_en_refuse: assert property (clk_en && state_ff == 3'h0
        && (alarm_in || !ctrl_word[2]) |=> state_ff != 3'h1)
        else $error("enable taken during stop request");
    a_brake_hold: assert property (
        (clk_en && brake_fitted && !drive_on_ff)[*2] |-> brake_hold_ff)
        else $error("brake not holding unpowered motor");
endmodule

bind svsmc_stop_ctrl svsmc_monitor #(.FRST_CYCLES(FRST_CYCLES)) u_mon (
    .ref_clk(ref_clk), .resetn(resetn), .clk_en(clk_en), .ctrl_word(ctrl_word),
    .alarm_in(alarm_in), .motor_stopped(motor_stopped), .brake_fitted(brake_fitted),
    .drive_on_ff(drive_on_ff), .stop_mode_ff(stop_mode_ff), .brake_hold_ff(brake_hold_ff),
    .fault_out_ff(fault_out_ff), .overtravel_ff(overtravel_ff), .state_ff(state_ff)
);

// ### test/svsmc_motor_model.sv
`timescale 1ns/10ps

module svsmc_motor_model #(
    parameter [7:0] STOP_CYC = 8'h08
) (
    input wire ref_clk,
    input wire resetn,
    input wire drive_on_ff,
    input wire [1:0] stop_mode_ff,
    output wire motor_stopped
);
    reg [7:0] spin_cnt_ff;

    // Spins while driven with no stop profile, settles STOP_CYC cycles later
    always @(posedge ref_clk or negedge resetn) begin
        if (!resetn) begin
            spin_cnt_ff <= STOP_CYC;
        end else if (drive_on_ff && stop_mode_ff == 2'h0) begin
            spin_cnt_ff <= 8'h00;
        end else if (spin_cnt_ff != STOP_CYC) begin
            spin_cnt_ff <= spin_cnt_ff + 8'h01;
        end
    end
    assign motor_stopped = (spin_cnt_ff == STOP_CYC);
endmodule

// ### test/servo_stop_method_control_tb_top.sv
`timescale 1ns/10ps

module servo_stop_method_control_tb_top;
    localparam [15:0] FRST = 16'h0014;
    reg ref_clk = 1'b0;
    reg resetn = 1'b0;
    reg od_wr = 1'b0;
    reg bus_mode = 1'b1;
    reg enable_req = 1'b0;
    reg alarm_in = 1'b0;
    reg fault_reset = 1'b0;
    reg estop_in = 1'b0;
    reg cmd_fwd = 1'b0;
    reg cmd_rev = 1'b0;
    reg brake_fitted = 1'b1;
    reg [15:0] od_index = 16'h0000;
    reg [15:0] od_wdata = 16'h0000;
    reg [15:0] ctrl_word = 16'h000F;
    reg [4:0] gen_in = 5'h00;
    wire [15:0] od_rdata_ff;
    wire [1:0] stop_mode_ff;
    wire [2:0] state_ff;
    wire drive_on_ff, pos_lock_ff, brake_hold_ff, fault_out_ff;
    wire fwd_block_ff, rev_block_ff, overtravel_ff, motor_stopped;
    integer failures = 0;
    integer n_tests = 0;
    reg [15:0] i;
    reg [15:0] k;
    reg clk_en = 1'b1;

    always #50 ref_clk = ~ref_clk;

    svsmc_stop_ctrl #(.FRST_CYCLES(FRST)) u_dut (
        .ref_clk(ref_clk), .resetn(resetn), .clk_en(clk_en), .od_index(od_index),
        .od_wr(od_wr), .od_wdata(od_wdata), .od_rdata_ff(od_rdata_ff),
        .bus_mode(bus_mode), .ctrl_word(ctrl_word), .enable_req(enable_req),
        .alarm_in(alarm_in), .fault_reset(fault_reset), .gen_in(gen_in),
        .estop_in(estop_in), .cmd_fwd(cmd_fwd), .cmd_rev(cmd_rev),
        .motor_stopped(motor_stopped), .brake_fitted(brake_fitted),
        .drive_on_ff(drive_on_ff), .stop_mode_ff(stop_mode_ff), .pos_lock_ff(pos_lock_ff),
        .brake_hold_ff(brake_hold_ff), .fault_out_ff(fault_out_ff),
        .fwd_block_ff(fwd_block_ff), .rev_block_ff(rev_block_ff),
        .overtravel_ff(overtravel_ff), .state_ff(state_ff)
    );

    svsmc_motor_model u_motor (
        .ref_clk(ref_clk), .resetn(resetn), .drive_on_ff(drive_on_ff),
        .stop_mode_ff(stop_mode_ff), .motor_stopped(motor_stopped)
    );

    task chk(input [8*8-1:0] nm, input [15:0] exp, input [15:0] got);
        n_tests = n_tests + 1;
        if (got !== exp) begin
            failures = failures + 1;
            $display("BAD %0s expected %h seen %h", nm, exp, got);
        end
    endtask

    task tick;
        @(negedge ref_clk);
    endtask

    task wr(input [15:0] a, input [15:0] d);
        tick;
        od_index = a;
        od_wdata = d;
        od_wr = 1'b1;
        tick;
        od_wr = 1'b0;
    endtask

    task rd(input [15:0] a, input [15:0] exp);
        tick;
        od_index = a;
        tick;
        chk("rdata", exp, od_rdata_ff);
    endtask

    // Bounded wait; k keeps the number of cycles waited
    task wst(input [2:0] s);
        k = 16'h0000;
        while (state_ff !== s && k < 16'h012C) begin
            tick;
            k = k + 16'h0001;
        end
        chk("state", {13'h0000, s}, {13'h0000, state_ff});
    endtask

    task go_op;
        tick;
        enable_req = 1'b1;
        wst(3'h1);
    endtask

    task close_out;
        $display("checks %0d mismatches %0d", n_tests, failures);
        if (failures == 0 && n_tests > 0) begin
            $display("Testbench passed");
        end else begin
            $display("Testbench failed");
        end
        $finish;
    endtask

    initial begin
        #2000000;
        failures = failures + 1;
        close_out;
    end

    initial begin
        repeat (3) tick;
        resetn = 1'b1;
        rd(16'h605C, 16'h0002);
        rd(16'h605E, 16'h0001);
        rd(16'h2000, 16'h0006);
        rd(16'h605A, 16'h0002);
        wr(16'h1234, 16'hFFFF);
        rd(16'h1234, 16'h0000);
        $display("test registers finished");
        for (i = 16'h0000; i < 16'h0004; i = i + 16'h0001) begin
            wr(16'h605C, i);
            go_op;
            enable_req = 1'b0;
            tick;
            chk("state", 16'h0002, {13'h0000, state_ff});
            chk("mode", i, {14'h0000, stop_mode_ff});
            chk("drive", 16'h0001, {15'h0000, drive_on_ff});
            wst(3'h0);
            chk("drive", 16'h0000, {15'h0000, drive_on_ff});
        end
        wr(16'h605C, 16'h0001);
        go_op;
        bus_mode = 1'b0;
        enable_req = 1'b0;
        tick;
        chk("mode", 16'h0000, {14'h0000, stop_mode_ff});
        wst(3'h0);
        bus_mode = 1'b1;
        // Clock enable low must hold the state machine still
        go_op;
        clk_en = 1'b0;
        enable_req = 1'b0;
        repeat (2) tick;
        chk("frozen", 16'h0001, {13'h0000, state_ff});
        clk_en = 1'b1;
        tick;
        chk("state", 16'h0002, {13'h0000, state_ff});
        wst(3'h0);
        repeat (3) tick;
        chk("brake", 16'h0001, {15'h0000, brake_hold_ff});
        brake_fitted = 1'b0;
        repeat (2) tick;
        chk("brake", 16'h0000, {15'h0000, brake_hold_ff});
        brake_fitted = 1'b1;
        $display("test disable finished");
        for (i = 16'h0000; i < 16'h0004; i = i + 16'h0001) begin
            wr(16'h605E, i);
            go_op;
            alarm_in = 1'b1;
            tick;
            chk("state", 16'h0004, {13'h0000, state_ff});
            chk("mode", i, {14'h0000, stop_mode_ff});
            wst(3'h5);
            chk("fault", 16'h0001, {15'h0000, fault_out_ff});
            rd(16'h2010, 16'h0508);
            fault_reset = 1'b1;
            repeat (2) tick;
            chk("state", 16'h0005, {13'h0000, state_ff});
            alarm_in = 1'b0;
            tick;
            fault_reset = 1'b0;
            chk("state", 16'h0006, {13'h0000, state_ff});
            wst(3'h0);
            chk("delay", FRST + 16'h0001, k);
            chk("fault", 16'h0000, {15'h0000, fault_out_ff});
        end
        $display("test fault finished");
        go_op;
        ctrl_word = 16'h000B;
        tick;
        chk("state", 16'h0003, {13'h0000, state_ff});
        wst(3'h0);
        tick;
        chk("state", 16'h0000, {13'h0000, state_ff});
        ctrl_word = 16'h000F;
        wst(3'h1);
        estop_in = 1'b1;
        tick;
        chk("state", 16'h0003, {13'h0000, state_ff});
        estop_in = 1'b0;
        wst(3'h1);
        wr(16'h2000, 16'h006A);
        wst(3'h3);
        estop_in = 1'b1;
        wst(3'h1);
        $display("test quick stop finished");
        gen_in = 5'h02;
        wr(16'h2001, 16'h0002);
        wr(16'h2002, 16'h0067);
        rd(16'h2002, 16'h0067);
        tick;
        cmd_fwd = 1'b1;
        gen_in = 5'h03;
        repeat (2) tick;
        chk("fwdblk", 16'h0001, {15'h0000, fwd_block_ff});
        chk("ot", 16'h0001, {15'h0000, overtravel_ff});
        chk("mode", 16'h0003, {14'h0000, stop_mode_ff});
        repeat (12) tick;
        chk("lock", 16'h0001, {15'h0000, pos_lock_ff});
        cmd_fwd = 1'b0;
        cmd_rev = 1'b1;
        repeat (2) tick;
        chk("ot", 16'h0000, {15'h0000, overtravel_ff});
        chk("fwdblk", 16'h0001, {15'h0000, fwd_block_ff});
        gen_in = 5'h01;
        repeat (2) tick;
        chk("revblk", 16'h0001, {15'h0000, rev_block_ff});
        cmd_rev = 1'b0;
        enable_req = 1'b0;
        wst(3'h0);
        $display("test overtravel finished");
        close_out;
    end
endmodule
